// file: core/twm_pkg.sv
// package: register map, field layout and mode encodings for the timer wave block
`default_nettype none
package twm_pkg;
	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL_A = 8'h00;
	localparam logic [7:0] OFF_CTRL_B = 8'h04;
	localparam logic [7:0] OFF_CMP_A = 8'h08;
	localparam logic [7:0] OFF_CMP_B = 8'h0c;
	localparam logic [7:0] OFF_CAPTURE = 8'h10;
	localparam logic [7:0] OFF_COUNT = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_MASK = 8'h1c;
	localparam logic [7:0] OFF_PIN = 8'h20;
	// ==========================================================
	// control register a fields
	localparam int CA_ACT_A_LSB = 6;
	localparam int CA_ACT_B_LSB = 4;
	localparam int CA_FORCE_A = 3;
	localparam int CA_FORCE_B = 2;
	localparam int CA_MODE_LSB = 0;
	// control register b fields
	localparam int CB_MODE_LSB = 3;
	localparam int CB_RUN = 0;
	// status bits
	localparam int ST_OVF = 0;
	localparam int ST_MATCH_A = 1;
	localparam int ST_MATCH_B = 2;
	localparam int ST_TOP = 3;
	// ==========================================================
	// reset values
	localparam logic [7:0] CTRL_A_RST = 8'h00;
	localparam logic [7:0] CTRL_B_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	// ==========================================================
	// tops and mode encodings
	localparam logic [15:0] TOP_MAX = 16'hffff;
	localparam logic [15:0] TOP_8 = 16'h00ff;
	localparam logic [15:0] TOP_9 = 16'h01ff;
	localparam logic [15:0] TOP_10 = 16'h03ff;
	localparam logic [15:0] BOTTOM = 16'h0000;
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_CTC_A = 4'h4;
	localparam logic [3:0] MODE_PFC_A = 4'h9;
	localparam logic [3:0] MODE_CTC_CAP = 4'hc;
	localparam logic [3:0] MODE_RESERVED = 4'hd;
	localparam logic [3:0] MODE_FAST_CAP = 4'he;
	localparam logic [3:0] MODE_FAST_A = 4'hf;
	typedef enum logic [1:0] {
		TWM_KIND_NONPWM,
		TWM_KIND_FAST,
		TWM_KIND_PC,
		TWM_KIND_PFC
	} twm_kind_t;
	typedef enum logic [1:0] {
		TWM_TOP_FIXED,
		TWM_TOP_CMPA,
		TWM_TOP_CAP
	} twm_topsrc_t;
	typedef enum logic [1:0] {
		TWM_AT_MAX,
		TWM_AT_TOP,
		TWM_AT_BOTTOM,
		TWM_AT_NOW
	} twm_when_t;
	typedef struct packed {
		twm_kind_t kind;
		twm_topsrc_t topsrc;
		logic [15:0] fixed_top;
		twm_when_t upd;
		twm_when_t ovf;
	} twm_mode_t;
	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} twm_apb_req_t;
endpackage
`default_nettype wire

// file: core/twm_wave.sv
// timer/counter with wave mode decode and two compare output channels
`default_nettype none
module twm_wave (
	input wire logic mclk,
	input wire logic resetn,
	input wire twm_pkg::twm_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] pin_dir_out,
	input wire logic [1:0] port_data,
	output logic wave_out_a,
	output logic wave_out_b,
	output logic [1:0] pin_oe,
	output logic irq
);
	// ==========================================================
	// registers
	logic [7:0] ctrl_a_r;
	logic [7:0] ctrl_b_r;
	logic [15:0] cmp_buf_a_r, cmp_buf_b_r, cmp_a_r, cmp_b_r, capture_r, count_r;
	logic down_r;
	logic [3:0] status_r, mask_r;
	logic out_a_r, out_b_r;
	logic [1:0] force_r;
	logic [3:0] wave_mode;
	twm_pkg::twm_mode_t md;
	logic [15:0] top;
	logic running, wr, rd, at_top, at_bottom, at_max;
	logic match_a, match_b, upd_now, ovf_ev, top_ev;
	logic [1:0] act_a, act_b;
	logic [31:0] rdata_nxt;

	assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd = apb_req.psel & ~apb_req.pwrite;
	assign wave_mode = {ctrl_b_r[twm_pkg::CB_MODE_LSB +: 2], ctrl_a_r[twm_pkg::CA_MODE_LSB +: 2]};
	assign act_a = ctrl_a_r[twm_pkg::CA_ACT_A_LSB +: 2];
	assign act_b = ctrl_a_r[twm_pkg::CA_ACT_B_LSB +: 2];
	assign running = ctrl_b_r[twm_pkg::CB_RUN];
	// ==========================================================
	// mode decode
	always_comb begin
		md = '{twm_pkg::TWM_KIND_NONPWM, twm_pkg::TWM_TOP_FIXED, twm_pkg::TOP_MAX,
			twm_pkg::TWM_AT_NOW, twm_pkg::TWM_AT_MAX};
		case (wave_mode)
			4'h0: md.fixed_top = twm_pkg::TOP_MAX;
			4'h4: md.topsrc = twm_pkg::TWM_TOP_CMPA;
			4'hc: md.topsrc = twm_pkg::TWM_TOP_CAP;
			4'h1, 4'h2, 4'h3, 4'ha, 4'hb: begin
				md.kind = twm_pkg::TWM_KIND_PC;
				md.upd = twm_pkg::TWM_AT_TOP;
				md.ovf = twm_pkg::TWM_AT_BOTTOM;
				md.fixed_top = (wave_mode == 4'h1) ? twm_pkg::TOP_8 :
					(wave_mode == 4'h2) ? twm_pkg::TOP_9 : twm_pkg::TOP_10;
				md.topsrc = (wave_mode == 4'ha) ? twm_pkg::TWM_TOP_CAP :
					(wave_mode == 4'hb) ? twm_pkg::TWM_TOP_CMPA : twm_pkg::TWM_TOP_FIXED;
			end
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: begin
				md.kind = twm_pkg::TWM_KIND_FAST;
				md.upd = twm_pkg::TWM_AT_BOTTOM;
				md.ovf = twm_pkg::TWM_AT_TOP;
				md.fixed_top = (wave_mode == 4'h5) ? twm_pkg::TOP_8 :
					(wave_mode == 4'h6) ? twm_pkg::TOP_9 : twm_pkg::TOP_10;
				md.topsrc = (wave_mode == twm_pkg::MODE_FAST_CAP) ? twm_pkg::TWM_TOP_CAP :
					(wave_mode == twm_pkg::MODE_FAST_A) ? twm_pkg::TWM_TOP_CMPA :
					twm_pkg::TWM_TOP_FIXED;
			end
			4'h8, 4'h9: begin
				md.kind = twm_pkg::TWM_KIND_PFC;
				md.upd = twm_pkg::TWM_AT_BOTTOM;
				md.ovf = twm_pkg::TWM_AT_BOTTOM;
				md.topsrc = (wave_mode == 4'h8) ? twm_pkg::TWM_TOP_CAP : twm_pkg::TWM_TOP_CMPA;
			end
			// reserved mode behaves as normal counting
			default: md.fixed_top = twm_pkg::TOP_MAX;
		endcase
	end

	always_comb begin
		case (md.topsrc)
			twm_pkg::TWM_TOP_CMPA: top = cmp_a_r;
			twm_pkg::TWM_TOP_CAP: top = capture_r;
			default: top = md.fixed_top;
		endcase
	end
	assign at_top = (count_r == top);
	assign at_bottom = (count_r == twm_pkg::BOTTOM);
	assign at_max = (count_r == twm_pkg::TOP_MAX);
	assign match_a = running & (count_r == cmp_a_r);
	assign match_b = running & (count_r == cmp_b_r);
	always_comb begin
		case (md.upd)
			twm_pkg::TWM_AT_TOP: upd_now = running & at_top;
			twm_pkg::TWM_AT_BOTTOM: upd_now = running & at_bottom;
			default: upd_now = 1'b1;
		endcase
		case (md.ovf)
			twm_pkg::TWM_AT_TOP: ovf_ev = running & at_top;
			twm_pkg::TWM_AT_BOTTOM: ovf_ev = running & at_bottom & down_r;
			default: ovf_ev = running & at_max;
		endcase
	end
	assign top_ev = running & at_top;
	// ==========================================================
	// counter
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			count_r <= twm_pkg::WORD_RST;
			down_r <= 1'b0;
		end else if (wr && apb_req.paddr == twm_pkg::OFF_COUNT) begin
			count_r <= apb_req.pwdata[15:0];
		end else if (running) begin
			// dual slope turns round at top and bottom
			if (md.kind == twm_pkg::TWM_KIND_PC || md.kind == twm_pkg::TWM_KIND_PFC) begin
				if (at_top) begin
					down_r <= 1'b1;
					count_r <= count_r - 16'h0001;
				end else if (at_bottom) begin
					down_r <= 1'b0;
					count_r <= count_r + 16'h0001;
				end else begin
					count_r <= down_r ? count_r - 16'h0001 : count_r + 16'h0001;
				end
			end else begin
				down_r <= 1'b0;
				// single slope wraps at top, fixed tops included; forced strobes never reach here
				count_r <= at_top ? twm_pkg::BOTTOM : count_r + 16'h0001;
			end
		end
	end
	// ==========================================================
	// compare buffers
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cmp_buf_a_r <= twm_pkg::WORD_RST;
			cmp_buf_b_r <= twm_pkg::WORD_RST;
			cmp_a_r <= twm_pkg::WORD_RST;
			cmp_b_r <= twm_pkg::WORD_RST;
			capture_r <= twm_pkg::WORD_RST;
		end else begin
			if (wr && apb_req.paddr == twm_pkg::OFF_CMP_A)
				cmp_buf_a_r <= apb_req.pwdata[15:0];
			if (wr && apb_req.paddr == twm_pkg::OFF_CMP_B)
				cmp_buf_b_r <= apb_req.pwdata[15:0];
			if (wr && apb_req.paddr == twm_pkg::OFF_CAPTURE)
				capture_r <= apb_req.pwdata[15:0];
			if (upd_now) begin
				cmp_a_r <= cmp_buf_a_r;
				cmp_b_r <= cmp_buf_b_r;
			end
		end
	end
	// ==========================================================
	// control registers and force strobes
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctrl_a_r <= twm_pkg::CTRL_A_RST;
			ctrl_b_r <= twm_pkg::CTRL_B_RST;
			force_r <= 2'b00;
		end else begin
			force_r <= 2'b00;
			if (wr && apb_req.paddr == twm_pkg::OFF_CTRL_A) begin
				// strobe bits are not stored; they read back as zero
				ctrl_a_r <= apb_req.pwdata[7:0] & 8'hf3;
				// gated later by the mode written alongside, not the old one
				force_r <= {apb_req.pwdata[twm_pkg::CA_FORCE_A],
					apb_req.pwdata[twm_pkg::CA_FORCE_B]};
			end
			if (wr && apb_req.paddr == twm_pkg::OFF_CTRL_B)
				ctrl_b_r <= apb_req.pwdata[7:0] & 8'h19;
		end
	end
	// ==========================================================
	// waveform output units
	function automatic logic wave_next(input logic cur, input logic [1:0] act,
		input twm_pkg::twm_kind_t kind, input logic match, input logic forced,
		input logic cmp_is_top, input logic bottom, input logic down, input logic tog_ok);
		logic n;
		n = cur;
		case (kind)
			twm_pkg::TWM_KIND_NONPWM: begin
				if (match || forced) begin
					case (act)
						2'b01: n = ~cur;
						2'b10: n = 1'b0;
						2'b11: n = 1'b1;
						default: n = cur;
					endcase
				end
			end
			twm_pkg::TWM_KIND_FAST: begin
				if (act[1]) begin
					if (bottom)
						n = ~act[0];
					else if (match && !cmp_is_top)
						n = act[0];
				end else if (act == 2'b01 && tog_ok && match) begin
					n = ~cur;
				end
			end
			default: begin
				if (act[1] && match)
					n = down ? ~act[0] : act[0];
				else if (act == 2'b01 && tog_ok && match)
					n = ~cur;
			end
		endcase
		return n;
	endfunction

	logic tog_a_ok;
	assign tog_a_ok = (md.kind == twm_pkg::TWM_KIND_FAST) ? (wave_mode == twm_pkg::MODE_FAST_A) :
		(wave_mode == twm_pkg::MODE_PFC_A || wave_mode == twm_pkg::MODE_FAST_CAP);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			out_a_r <= 1'b0;
			out_b_r <= 1'b0;
		end else begin
			// bottom action lands on the edge that wraps the count to bottom
			out_a_r <= wave_next(out_a_r, act_a, md.kind, match_a, force_r[1],
				cmp_a_r == top, running & at_top, down_r, tog_a_ok);
			out_b_r <= wave_next(out_b_r, act_b, md.kind, match_b, force_r[0],
				cmp_b_r == top, running & at_top, down_r, 1'b0);
		end
	end

	// pin mux: waveform overrides port data when action nonzero, except code 01 in pwm modes: always for channel b, for channel a where it may not toggle
	logic conn_a, conn_b;
	// code 01 stays on the port in pwm modes unless channel a may toggle
	assign conn_a = (act_a != 2'b00) && !(act_a == 2'b01 &&
		md.kind != twm_pkg::TWM_KIND_NONPWM && !tog_a_ok);
	assign conn_b = (act_b != 2'b00) && !(act_b == 2'b01 &&
		md.kind != twm_pkg::TWM_KIND_NONPWM);
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wave_out_a <= 1'b0;
			wave_out_b <= 1'b0;
		end else begin
			wave_out_a <= conn_a ? out_a_r : port_data[0];
			wave_out_b <= conn_b ? out_b_r : port_data[1];
		end
	end
	// driver enabled only by the direction bit, as software must set it
	assign pin_oe = pin_dir_out;
	// ==========================================================
	// status and interrupt
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			status_r <= twm_pkg::FLAGS_RST;
			mask_r <= twm_pkg::FLAGS_RST;
		end else begin
			// set beats clear; forced strobes never set a flag
			status_r <= (status_r & ~((wr && apb_req.paddr == twm_pkg::OFF_STATUS) ?
				apb_req.pwdata[3:0] : 4'h0)) |
				{top_ev, match_b, match_a, ovf_ev};
			if (wr && apb_req.paddr == twm_pkg::OFF_MASK)
				mask_r <= apb_req.pwdata[3:0];
		end
	end
	assign irq = |(status_r & mask_r);
	// ==========================================================
	// apb read
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (apb_req.paddr)
			twm_pkg::OFF_CTRL_A: rdata_nxt[7:0] = ctrl_a_r;
			twm_pkg::OFF_CTRL_B: rdata_nxt[7:0] = ctrl_b_r;
			twm_pkg::OFF_CMP_A: rdata_nxt[15:0] = cmp_buf_a_r;
			twm_pkg::OFF_CMP_B: rdata_nxt[15:0] = cmp_buf_b_r;
			twm_pkg::OFF_CAPTURE: rdata_nxt[15:0] = capture_r;
			twm_pkg::OFF_COUNT: rdata_nxt[15:0] = count_r;
			twm_pkg::OFF_STATUS: rdata_nxt[3:0] = status_r;
			twm_pkg::OFF_MASK: rdata_nxt[3:0] = mask_r;
			twm_pkg::OFF_PIN: rdata_nxt[1:0] = {out_b_r, out_a_r};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge mclk) begin
		if (!resetn)
			prdata <= 32'h0000_0000;
		else if (rd && !apb_req.penable)
			prdata <= rdata_nxt;
	end
	assign pready = 1'b1;
	assign pslverr = apb_req.psel & apb_req.penable & (apb_req.paddr > twm_pkg::OFF_PIN |
		apb_req.paddr[1:0] != 2'b00);
endmodule
`default_nettype wire

// file: sim/timer_wave_mode_and_compare_output_bench.sv
// bench: register, force, port and pwm scenarios for the timer wave block
`default_nettype none
module timer_wave_mode_and_compare_output_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, resetn, pready, pslverr, serr, wa, wb, irq;
	twm_pkg::twm_apb_req_t req;
	logic [31:0] prdata, r;
	logic [1:0] dir, pdat, oe, lvl;
	int num_errors, samples_checked;
	twm_wave dut_u (.mclk(mclk), .resetn(resetn), .apb_req(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_dir_out(dir), .port_data(pdat),
		.wave_out_a(wa), .wave_out_b(wb), .pin_oe(oe), .irq(irq));
	twm_pins pins_u (.pin_oe(oe), .wave_out_a(wa), .wave_out_b(wb), .pin_level(lvl));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// ==========
	// shared tasks
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		req <= '{a, 1'b1, 1'b0, w, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			tally_and_finish();
		end
		r = prdata;
		serr = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	// counts high cycles of pin a over 90 clocks, a whole number of periods
	task automatic duty(input logic [7:0] ca, input logic [7:0] cb, input int exp);
		int h;
		apb(1'b1, twm_pkg::OFF_CTRL_B, {24'h0, cb});
		apb(1'b1, twm_pkg::OFF_CTRL_A, {24'h0, ca});
		repeat (40) @(posedge mclk);
		h = 0;
		for (int i = 0; i < 90; i++) begin
			@(posedge mclk);
			h += wa;
		end
		check("duty", h, exp);
	endtask
	// ==========
	// scenarios
	task automatic s_regs();
		apb(1'b0, twm_pkg::OFF_CTRL_A, 32'h0);
		check("ctrl_a reset", r, 32'h0);
		apb(1'b1, twm_pkg::OFF_CTRL_A, 32'hff);
		apb(1'b0, twm_pkg::OFF_CTRL_A, 32'h0);
		check("ctrl_a", r, 32'hf3);
		apb(1'b1, twm_pkg::OFF_CTRL_B, 32'hff);
		apb(1'b0, twm_pkg::OFF_CTRL_B, 32'h0);
		check("ctrl_b", r, 32'h19);
		apb(1'b0, 8'h24, 32'h0);
		check("unmapped", {serr, r[30:0]}, 32'h80000000);
		apb(1'b1, twm_pkg::OFF_CTRL_B, 32'h0);
		apb(1'b1, twm_pkg::OFF_COUNT, 32'h0);
	endtask
	task automatic s_force();
		logic [7:0] cw [6] = '{8'hc8, 8'h88, 8'h48, 8'h48, 8'h7c, 8'h88};
		logic [1:0] ex [6] = '{2'b01, 2'b00, 2'b01, 2'b00, 2'b11, 2'b00};
		apb(1'b1, twm_pkg::OFF_STATUS, 32'hf);
		apb(1'b1, twm_pkg::OFF_COUNT, 32'h5);
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, twm_pkg::OFF_CTRL_A, {24'h0, cw[i]});
			repeat (2) @(posedge mclk);
			@(negedge mclk);
			check("forced pins", {30'h0, wb, wa}, {30'h0, ex[i]});
			if (i == 4) check("pin level", {30'h0, lvl}, 32'h1);
		end
		apb(1'b0, twm_pkg::OFF_STATUS, 32'h0);
		check("status", r, 32'h0);
		apb(1'b0, twm_pkg::OFF_COUNT, 32'h0);
		check("count", r, 32'h5);
	endtask
	task automatic s_port();
		pdat <= 2'b01;
		apb(1'b1, twm_pkg::OFF_CTRL_A, 32'h0);
		for (int i = 1; i < 3; i++) begin
			pdat <= i[1:0];
			repeat (2) @(posedge mclk);
			check("port pins", {30'h0, wb, wa}, i);
		end
	endtask
	task automatic s_pwm();
		apb(1'b1, twm_pkg::OFF_CMP_A, 32'h2);
		apb(1'b1, twm_pkg::OFF_CAPTURE, 32'h9);
		apb(1'b1, twm_pkg::OFF_CTRL_B, 32'h18);
		apb(1'b1, twm_pkg::OFF_CTRL_A, 32'hca);
		repeat (2) @(posedge mclk);
		check("pwm force", {31'h0, wa}, 32'h0);
		pdat <= 2'b01;
		apb(1'b1, twm_pkg::OFF_CTRL_A, 32'h42);
		repeat (2) @(posedge mclk);
		check("code 01 mode 14", {31'h0, wa}, 32'h1);
		apb(1'b1, twm_pkg::OFF_CTRL_A, 32'h43);
		repeat (2) @(posedge mclk);
		check("code 01 mode 15", {31'h0, wa}, 32'h0);
		duty(8'h82, 8'h19, 27);
		duty(8'hc2, 8'h19, 63);
		duty(8'h82, 8'h11, 20);
		apb(1'b1, twm_pkg::OFF_CTRL_B, 32'h10);
		apb(1'b0, twm_pkg::OFF_STATUS, 32'h0);
		check("overflow", r & 32'h1, 32'h1);
		apb(1'b1, twm_pkg::OFF_MASK, 32'h1);
		@(negedge mclk);
		check("irq on", {31'h0, irq}, 32'h1);
		apb(1'b1, twm_pkg::OFF_STATUS, 32'hf);
		@(negedge mclk);
		check("irq cleared", {31'h0, irq}, 32'h0);
		apb(1'b1, twm_pkg::OFF_MASK, 32'h0);
	endtask
	initial begin
		resetn = 1'b0;
		req = '0;
		dir = 2'b01;
		pdat = 2'b00;
		num_errors = 0;
		samples_checked = 0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		s_regs();
		s_force();
		s_port();
		s_pwm();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// file: sim/twm_pins.sv
// partner model: port pin loads behind the two waveform pins
`default_nettype none
module twm_pins (
	input wire logic [1:0] pin_oe,
	input wire logic wave_out_a,
	input wire logic wave_out_b,
	output logic [1:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// load model
	// pull-down, so an undriven pin never echoes the last wave level
	assign pin_level = pin_oe & {wave_out_b, wave_out_a};
endmodule
`default_nettype wire

// file: sim/twm_wave_properties.sv
// checker: port-level properties of the timer wave block
`default_nettype none
module twm_wave_properties (
	input wire logic mclk,
	input wire logic resetn,
	input wire twm_pkg::twm_apb_req_t apb_req,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] port_data,
	input wire logic wave_out_a,
	input wire logic irq
);
	logic [1:0] mode_hi_r;
	logic run_r;
	logic acc, wr, wra, bad;
	logic [3:0] m;
	logic [31:0] d;
	assign acc = apb_req.psel & apb_req.penable & pready;
	assign wr = acc & apb_req.pwrite;
	assign wra = wr && apb_req.paddr == twm_pkg::OFF_CTRL_A;
	assign d = apb_req.pwdata;
	assign bad = apb_req.paddr > 8'h20 || apb_req.paddr[1:0] != 2'h0;
	assign m = {mode_hi_r, d[1:0]};
	// upper mode bits and run live in the other control register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			mode_hi_r <= 2'h0;
			run_r <= 1'b0;
		end else if (wr && apb_req.paddr == twm_pkg::OFF_CTRL_B) begin
			mode_hi_r <= d[4:3];
			run_r <= d[0];
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ==========
	// properties
	property p_err_bad;
		acc && bad |-> pslverr;
	endproperty
	a_err_bad: assert property (p_err_bad) else $error("no error on unmapped access");
	property p_err_ok;
		acc && !bad |-> !pslverr;
	endproperty
	a_err_ok: assert property (p_err_ok) else $error("error on mapped access");
	property p_rd_bad;
		acc && !apb_req.pwrite && bad |-> prdata == 32'h0;
	endproperty
	a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not zero");
	property p_force_zero;
		acc && !apb_req.pwrite && apb_req.paddr == twm_pkg::OFF_CTRL_A |-> prdata[3:2] == 2'h0;
	endproperty
	a_force_zero: assert property (p_force_zero) else $error("force bits read one");
	property p_port;
		wra && d[7:6] == 2'h0 ##1 $stable(port_data)[*2] |-> wave_out_a == port_data[0];
	endproperty
	a_port: assert property (p_port) else $error("pin a not on port data");
	property p_mask_off;
		wr && apb_req.paddr == twm_pkg::OFF_MASK && d[3:0] == 4'h0 |=> !irq;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("irq with all masked");
	property p_force_set;
		wra && d[3] && d[7:6] == 2'h3 && m inside {4'h0, 4'h4, 4'hc} |-> ##[1:3] wave_out_a;
	endproperty
	a_force_set: assert property (p_force_set) else $error("forced set missing");
	property p_pwm_noforce;
		wra && d[3] && d[7:6] == 2'h3 && m inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf}
			&& !run_r && !wave_out_a |=> !wave_out_a[*3];
	endproperty
	a_pwm_noforce: assert property (p_pwm_noforce) else $error("force acted in pwm");
	c_force: cover property (wra && d[3]);
	c_irq: cover property (irq);
	c_err: cover property (acc && bad);
endmodule
bind twm_wave twm_wave_properties chk_u (.mclk(mclk), .resetn(resetn), .apb_req(apb_req),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .port_data(port_data),
	.wave_out_a(wave_out_a), .irq(irq));
`default_nettype wire
